// ### verilog/indirect_register_access.v
// Purpose: apb slave holding the indirect bank select, offset and data registers
// Assumes: one clock, asynchronous active-high reset, apb3 master
// Notes:   data reads take two wait states while the bank is fetched
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "indirect_access_map.vh"

// Overview of operation
// - select, offset, data at 0x40 to 0x42
// - data accesses go to chosen bank, stored offset
// - codes 0x04 and 0x08 select bank for write
// - codes 0x05 and 0x09 select bank for read
// - data write stores byte at current offset
// - data read returns bank byte at offset
// - auto increment bumps offset after each completed data access
module indirect_register_access (
	input  wire        core_clk_i,
	input  wire        sys_rst_i,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr
);

	// one-hot states; default branch returns an illegal code to idle
	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_FETCH = 3'b010;
	localparam [2:0] ST_DONE  = 3'b100;

	reg  [7:0] sel_ff;
	reg  [7:0] ofs_ff;
	reg  [2:0] st_ff;
	reg  [2:0] nxt_st;
	reg  [7:0] rd_err_ff;
	wire       p0_w;
	wire       p1_w;
	wire       rd_w;
	wire       ainc_w;
	wire [7:0] rdata0_w;
	wire [7:0] rdata1_w;
	wire       acc_w;
	wire       word_ok_w;
	wire [9:0] idx_w;
	wire       hit_sel_w;
	wire       hit_ofs_w;
	wire       hit_dat_w;
	wire       hit_sts_w;
	wire       dat_wr_w;
	wire       dat_rd_w;
	wire       fetch_w;
	wire       bank_ok_w;
	reg  [7:0] rbyte_w;
	wire       wr_take_w;
	wire       rd_wait_w;
	wire       sel_we_w;
	wire       ofs_we_w;
	wire       sts_we_w;
	wire       bump_w;
	wire       err_map_w;
	wire       err_nobank_w;
	wire       err_dir_w;
	wire       bank0_we_w;
	wire       bank1_we_w;
	wire       bank0_re_w;
	wire       bank1_re_w;
	reg  [7:0] nxt_sel;
	reg  [7:0] nxt_ofs;
	reg  [7:0] nxt_cnt;
	reg [31:0] nxt_prdata;

	////////////////////////////////////////////////////////////////////////
	// address decode

	// compares a word index against a register index
	function hit;
		input [9:0] idx;
		input [7:0] reg_idx;
		begin
			hit = (idx == {2'b00, reg_idx});
		end
	endfunction

	// offset step; wraps at 0xFF
	function [7:0] inc8;
		input [7:0] val;
		begin
			inc8 = val + 8'h01;
		end
	endfunction

	// refused access count; holds at 0xFF instead of wrapping
	function [7:0] sat_inc8;
		input [7:0] val;
		begin
			sat_inc8 = (val == 8'hFF) ? val : inc8(val);
		end
	endfunction

	// word index is paddr[11:2]; low two bits must be zero
	// all index bits are compared, so no register aliases
	// anywhere else in the main space
	assign acc_w     = psel & penable;
	assign word_ok_w = (paddr[1:0] == 2'b00);
	assign idx_w     = paddr[11:2];
	assign hit_sel_w = word_ok_w & hit(idx_w, `IND_SEL_IDX);
	assign hit_ofs_w = word_ok_w & hit(idx_w, `IND_OFS_IDX);
	assign hit_dat_w = word_ok_w & hit(idx_w, `IND_DAT_IDX);
	assign hit_sts_w = word_ok_w & hit(idx_w, `IND_STS_IDX);
	assign bank_ok_w = p0_w | p1_w;

	////////////////////////////////////////////////////////////////////////
	// select decode and the two banks

	indirect_sel_decode u_dec (
		.sel_i  (sel_ff),
		.p0_o   (p0_w),
		.p1_o   (p1_w),
		.rd_o   (rd_w),
		.ainc_o (ainc_w)
	);

	// a data write lands in one cycle, at the access phase edge
	assign dat_wr_w = acc_w & pwrite & hit_dat_w & (st_ff == ST_IDLE);
	// a data read is started once, then waits for the bank
	assign dat_rd_w = acc_w & ~pwrite & hit_dat_w;
	assign fetch_w  = dat_rd_w & (st_ff == ST_IDLE) & rd_w;

	// per bank strobes; only the chosen bank ever sees one
	assign bank0_we_w = dat_wr_w & p0_w;
	assign bank1_we_w = dat_wr_w & p1_w;
	assign bank0_re_w = fetch_w & p0_w;
	assign bank1_re_w = fetch_w & p1_w;

	indirect_bank_mem u_bank0 (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.wr_en_i    (bank0_we_w),
		.rd_en_i    (bank0_re_w),
		.addr_i     (ofs_ff[`BANK_AW-1:0]),
		.wdata_i    (pwdata[7:0]),
		.rdata_o    (rdata0_w)
	);

	indirect_bank_mem u_bank1 (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.wr_en_i    (bank1_we_w),
		.rd_en_i    (bank1_re_w),
		.addr_i     (ofs_ff[`BANK_AW-1:0]),
		.wdata_i    (pwdata[7:0]),
		.rdata_o    (rdata1_w)
	);

	////////////////////////////////////////////////////////////////////////
	// read sequencing: idle, one fetch cycle, then the answer

	// data read timing, counted in access phase edges:
	//   edge 1: fetch strobe loads the bank read flop, state to fetch
	//   edge 2: read mux passes the bank byte into prdata, state to done
	//   edge 3: pready high, master takes prdata, offset bumps
	// no fetch starts outside idle, so one read is exactly one fetch
	// trade-off: two wait states buy a plain synchronous bank ram
	// writes land at edge 1 and never wait

	always @* begin
		case (st_ff)
			ST_IDLE: begin
				nxt_st = rd_wait_w ? ST_FETCH : ST_IDLE;
			end
			ST_FETCH: begin
				nxt_st = ST_DONE;
			end
			ST_DONE: begin
				nxt_st = ST_IDLE;
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
	end

	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st_ff <= ST_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// a data read that has to wait for the bank
	assign rd_wait_w    = dat_rd_w & rd_w & bank_ok_w;
	// data reads with read enable and a bank chosen wait for it; everything else answers at once
	assign pready       = ~rd_wait_w | (st_ff == ST_DONE);

	// refusal causes kept apart so each can be probed alone
	assign err_map_w    = ~(hit_sel_w | hit_ofs_w | hit_dat_w | hit_sts_w);
	assign err_nobank_w = hit_dat_w & ~bank_ok_w;
	// read enable off: the bank byte would be stale, so refuse it
	assign err_dir_w    = hit_dat_w & ~pwrite & ~rd_w;
	assign pslverr      = acc_w & pready & (err_map_w | err_nobank_w | err_dir_w);

	////////////////////////////////////////////////////////////////////////
	// control registers

	// write strobes, one per register; writes never wait
	assign wr_take_w = acc_w & pwrite;
	assign sel_we_w  = wr_take_w & hit_sel_w;
	assign ofs_we_w  = wr_take_w & hit_ofs_w;
	assign sts_we_w  = wr_take_w & hit_sts_w;
	// bump once per completed data access, never on a refused one
	assign bump_w    = ainc_w & bank_ok_w & (dat_wr_w | (st_ff == ST_DONE));

	// bank select next value
	always @* begin
		nxt_sel = sel_ff;
		if (sel_we_w) begin
			nxt_sel = pwdata[7:0];
		end
	end

	// bank select flop
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sel_ff <= `SEL_RST;
		end else begin
			sel_ff <= nxt_sel;
		end
	end

	// offset: software write wins; apb never overlaps it with a bump
	always @* begin
		nxt_ofs = ofs_ff;
		if (ofs_we_w) begin
			nxt_ofs = pwdata[7:0];
		end else if (bump_w) begin
			nxt_ofs = inc8(ofs_ff);
		end
	end

	// offset flop
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ofs_ff <= `OFS_RST;
		end else begin
			ofs_ff <= nxt_ofs;
		end
	end

	// count of data accesses refused for no bank selected; helps bring-up debug
	always @* begin
		nxt_cnt = rd_err_ff;
		if (sts_we_w) begin
			nxt_cnt = 8'h00;
		end else if (acc_w & err_nobank_w) begin
			nxt_cnt = sat_inc8(rd_err_ff);
		end
	end

	// refused count flop
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_err_ff <= 8'h00;
		end else begin
			rd_err_ff <= nxt_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux; bytes sit in the low lane, upper bits zero

	always @* begin
		rbyte_w = 8'h00;
		if (hit_sel_w) begin
			rbyte_w = sel_ff;
		end else if (hit_ofs_w) begin
			rbyte_w = ofs_ff;
		end else if (hit_dat_w) begin
			rbyte_w = p1_w ? rdata1_w : rdata0_w;
		end else if (hit_sts_w) begin
			rbyte_w = rd_err_ff;
		end
	end

	// read data next value; loads whenever a read is on the bus
	always @* begin
		nxt_prdata = prdata;
		if (psel & ~pwrite) begin
			nxt_prdata = {24'h00_0000, rbyte_w};
		end
	end

	// prdata flopped; sampled by the master only with pready
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prdata <= 32'h0000_0000;
		end else begin
			prdata <= nxt_prdata;
		end
	end

endmodule // indirect_register_access
`default_nettype wire

// ### verilog/indirect_access_map.vh
// Purpose: offsets, field positions and reset values of the indirect access port
// Assumes: 32-bit apb data, 8-bit registers in the low byte
// Notes:   bank side is two 64-entry byte banks, one per receiver port
`ifndef INDIRECT_ACCESS_MAP_VH
`define INDIRECT_ACCESS_MAP_VH

// main register space indices; byte address is four times the index
`define IND_SEL_IDX        8'h40
`define IND_OFS_IDX        8'h41
`define IND_DAT_IDX        8'h42
`define IND_STS_IDX        8'h43
`define IND_ADDR_W         10

// bank select field layout
`define SEL_RD_BIT         0
`define SEL_AINC_BIT       1
`define SEL_P0_BIT         2
`define SEL_P1_BIT         3

// documented bank select codes
`define SEL_P0_WR          8'h04
`define SEL_P1_WR          8'h08
`define SEL_P0_RD          8'h05
`define SEL_P1_RD          8'h09

// reset values
`define SEL_RST            8'h00
`define OFS_RST            8'h00
`define DAT_RST            8'h00

// target bank geometry
`define BANK_AW            6
`define BANK_DEPTH         64

`endif

// ### verilog/indirect_bank_mem.v
// Purpose: one receiver port's indirect configuration and status bank
// Assumes: single clock, one access per cycle
// Notes:   read data registered; reserved offsets store like any other
`timescale 1ns/1ps
`default_nettype none
`include "indirect_access_map.vh"

module indirect_bank_mem (
	input  wire                    core_clk_i,
	input  wire                    sys_rst_i,
	input  wire                    wr_en_i,
	input  wire                    rd_en_i,
	input  wire [`BANK_AW-1:0]     addr_i,
	input  wire [7:0]              wdata_i,
	output reg  [7:0]              rdata_o
);

	reg [7:0] mem_ff [0:`BANK_DEPTH-1];

	////////////////////////////////////////////////////////////////////////
	// storage; no reset so it maps onto plain ram
	always @(posedge core_clk_i) begin
		if (wr_en_i) begin
			mem_ff[addr_i] <= wdata_i;
		end
	end

	// registered read port
	always @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_o <= `DAT_RST;
		end else if (rd_en_i) begin
			rdata_o <= mem_ff[addr_i];
		end
	end

endmodule // indirect_bank_mem
`default_nettype wire

// ### verilog/indirect_sel_decode.v
// Purpose: decodes the bank select byte into port and direction
// Assumes: purely combinational
// Notes:   codes other than the four documented ones, with or without the auto increment bit, select no bank
`timescale 1ns/1ps
`default_nettype none
`include "indirect_access_map.vh"

module indirect_sel_decode (
	input  wire [7:0] sel_i,
	output wire       p0_o,
	output wire       p1_o,
	output wire       rd_o,
	output wire       ainc_o
);

	wire [7:0] code_w;

	// auto increment bit masked off before matching the codes
	assign code_w = sel_i & ~(8'h01 << `SEL_AINC_BIT);
	assign p0_o   = (code_w == `SEL_P0_WR) || (code_w == `SEL_P0_RD);
	assign p1_o   = (code_w == `SEL_P1_WR) || (code_w == `SEL_P1_RD);
	assign rd_o   = sel_i[`SEL_RD_BIT];
	assign ainc_o = sel_i[`SEL_AINC_BIT];

endmodule // indirect_sel_decode
`default_nettype wire

// ### test/indirect_register_access_assertions.sv
// Purpose: port checks of the indirect access apb slave
// Assumes: byte addresses 0x100 to 0x10C, data at 0x108
// Notes:   sel_ff shadows the bank select byte
`timescale 1ns/1ps
`default_nettype none
module indirect_register_access_assertions (
	input wire logic        core_clk_i,
	input wire logic        sys_rst_i,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	wire       acc = psel && penable;
	wire [9:0] idx = paddr[11:2];
	logic [7:0] sel_ff;
	////////////////////////////////////////////////////////////
	// shadow select, updated only on a taken write
	always @(posedge core_clk_i or posedge sys_rst_i)
		if (sys_rst_i) sel_ff <= 8'h00;
		else if (acc && pready && pwrite && paddr == 12'h100) sel_ff <= pwdata[7:0];
	unaligned_err_a: assert property (acc && pready && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("unaligned access not refused");
	unmapped_err_a: assert property (acc && pready && (idx < 10'h040 || idx > 10'h043)
		|-> pslverr) else $error("unmapped access not refused");
	ctl_nowait_a: assert property (acc && paddr inside {12'h100, 12'h104}
		|-> pready && !pslverr) else $error("control access stalled or refused");
	data_wr_a: assert property (acc && pwrite && paddr == 12'h108 |-> pready)
		else $error("data write stalled");
	wait_cause_a: assert property (acc && !pready |-> !pwrite && paddr == 12'h108)
		else $error("wait state outside a data read");
	rd_latency_a: assert property ($rose(penable) && psel && !pready |=> !pready ##1 pready)
		else $error("data read latency wrong");
	upper_zero_a: assert property (acc && pready && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	sel_readback_a: assert property (acc && pready && !pwrite && paddr == 12'h100
		|-> prdata[7:0] == sel_ff) else $error("select readback wrong");
endmodule // indirect_register_access_assertions
`default_nettype wire

// ### test/testbench.sv
// Purpose: self-checking bench of the indirect access port
// Assumes: one idle cycle between apb transfers
// Notes:   monitor pops expected {err,byte} per completed transfer
`timescale 1ns/1ps
`default_nettype none
`include "indirect_access_map.vh"
module testbench;
	logic        core_clk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [8:0]  exq[$];
	logic [7:0]  mem[2][4];
	int          n_mismatch, cmp_count, seed, p, i;
	indirect_register_access u_indirect_register_access (.core_clk_i(core_clk_i),
		.sys_rst_i(sys_rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		core_clk_i = 0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	task automatic chk(input [8:0] s, input [8:0] e, input string nm);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("[ERR] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic close_out;
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// apb master: hold request until pready, then one idle cycle
	task automatic xfer(input logic w, input [11:0] a, input [7:0] d, input [8:0] e);
		int n;
		exq.push_back(e);
		psel <= 1; pwrite <= w; paddr <= a; pwdata <= {24'h0, d};
		@(posedge core_clk_i) penable <= 1;
		n = 0;
		do begin @(posedge core_clk_i); n++; end while (!pready && n < 20);
		if (n >= 20) begin n_mismatch++; close_out; end
		psel <= 0; penable <= 0;
		@(posedge core_clk_i);
	endtask
	task automatic wr(input [11:0] a, input [7:0] d, input logic err);
		xfer(1, a, d, {err, 8'h00});
	endtask
	task automatic rd(input [11:0] a, input [7:0] e);
		xfer(0, a, 8'h00, {1'b0, e});
	endtask
	// monitor: a result is a taken access phase
	always @(posedge core_clk_i) if (psel && penable && pready)
		chk({pslverr, pwrite ? 8'h00 : prdata[7:0]}, exq.pop_front(), "resp");
	initial begin
		seed = 13; sys_rst_i = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
		repeat (3) @(posedge core_clk_i);
		sys_rst_i <= 0;
		rd(12'h100, 8'h00); rd(12'h104, 8'h00); rd(12'h10C, 8'h00);
		$display("reset test done");
		// same offsets in both banks, different data: banks must not alias
		for (p = 0; p < 2; p++) begin
			wr(12'h100, (p ? `SEL_P1_WR : `SEL_P0_WR) | 8'h02, 0);
			wr(12'h104, 8'h30, 0);
			for (i = 0; i < 4; i++) begin
				mem[p][i] = 8'($random(seed));
				wr(12'h108, mem[p][i], 0);
			end
			rd(12'h104, 8'h34);
		end
		for (p = 0; p < 2; p++) begin
			wr(12'h100, (p ? `SEL_P1_RD : `SEL_P0_RD) | 8'h02, 0);
			wr(12'h104, 8'h30, 0);
			for (i = 0; i < 4; i++) rd(12'h108, mem[p][i]);
		end
		$display("auto increment test done");
		wr(12'h100, `SEL_P0_WR, 0); wr(12'h104, 8'h05, 0);
		wr(12'h108, 8'hAA, 0); wr(12'h108, 8'h55, 0);
		wr(12'h100, `SEL_P0_RD, 0); wr(12'h104, 8'h05, 0);
		rd(12'h108, 8'h55); rd(12'h108, 8'h55); rd(12'h104, 8'h05);
		$display("fixed offset test done");
		wr(12'h200, 8'h00, 1); wr(12'h101, 8'h00, 1);
		wr(12'h100, 8'h00, 0); wr(12'h108, 8'h11, 1);
		// one refused data access counted, then cleared by a write
		rd(12'h10C, 8'h01); wr(12'h10C, 8'h00, 0); rd(12'h10C, 8'h00);
		$display("refusal test done");
		close_out;
	end
endmodule // testbench
bind indirect_register_access indirect_register_access_assertions
	u_indirect_register_access_assertions (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire
